/* src/gpa_map.svh */
// Register offsets, field positions, reset values and timing figures of the protection block
`ifndef GPA_MAP_SVH
`define GPA_MAP_SVH

`define GPA_ADDR_CTRL        8'h00
`define GPA_ADDR_MCFG        8'h04
`define GPA_ADDR_MINT0       8'h08
`define GPA_ADDR_MINT1       8'h0c
`define GPA_ADDR_MINT2       8'h10
`define GPA_ADDR_DINCFG      8'h14
`define GPA_ADDR_DECOUPLE    8'h18
`define GPA_ADDR_OCCFG       8'h1c
`define GPA_ADDR_CMD         8'h20
`define GPA_ADDR_STATUS      8'h24
`define GPA_ADDR_IRQ_STAT    8'h28
`define GPA_ADDR_IRQ_MASK    8'h2c
`define GPA_ADDR_RUN_HOURS   8'h30

`define GPA_CTRL_WARN_EN     0
`define GPA_CTRL_INVERSE_TIME_OVERCURRENT_EN     1
`define GPA_CTRL_INVERSE_TIME_OVERCURRENT_SHUT   2
`define GPA_CTRL_LATCH_ALL   3
`define GPA_CTRL_PIN_REQ     4

`define GPA_MCFG_EN_LSB      0
`define GPA_MCFG_SHUT_LSB    4
`define GPA_MCFG_DATE_LSB    8

`define GPA_CMD_DEC_CLR      3
`define GPA_CMD_OC_CLR       4

`define GPA_IRQ_MAINT        0
`define GPA_IRQ_DECOUPLE     1
`define GPA_IRQ_OC_WARN      2
`define GPA_IRQ_INVERSE_TIME_OVERCURRENT         3

`define GPA_PIN_STOP         0
`define GPA_PIN_MUTE         1
`define GPA_PIN_TICK         2
`define GPA_PIN_PAR          3
`define GPA_PIN_RUN          4
`define GPA_PIN_DIN          5
`define GPA_DIN_DEC_CLR      3

`define GPA_CTRL_RST         8'h03
`define GPA_MCFG_RST         12'h000
`define GPA_MINT_RST         24'h01000a
`define GPA_REMAIN_RST       32'h00008ca0
`define GPA_DINCFG_RST       16'h010f
`define GPA_DECOUPLE_RST     32'h00a00040
`define GPA_OCCFG_RST        32'h246401f4

`define GPA_CLK_HZ           25000000
`define GPA_MS_PER_S         1000
`define GPA_STOP_HOLD_S      10
`define GPA_COMBO_HOLD_MS    500
`define GPA_SEC_PER_HOUR     32'h00000e10
`define GPA_COOL_SHIFT       16

`endif

/* src/gpa_pkg.sv */
// Types of the generator protection and alarm block
`include "gpa_map.svh"

package gpa_pkg;

  localparam int GPA_PIN_W = 9;

  typedef struct packed {
    logic [GPA_PIN_W-1:0] sync1;
    logic [GPA_PIN_W-1:0] sync2;
    logic [GPA_PIN_W-1:0] sync3;
    logic [GPA_PIN_W-1:0] filt;
    logic                 stop_prev;
    logic [31:0]          presc;
    logic [31:0]          ms_cnt;
    logic [3:0][7:0]      din_cnt;
    logic [3:0]           din_act;
    logic [31:0]          stop_cnt;
    logic [31:0]          combo_cnt;
    logic [11:0]          run_sec;
    logic [31:0]          run_hours;
    logic [2:0][31:0]     remain;
    logic [2:0][7:0]      months;
    logic [2:0]           due;
    logic [7:0]           ctrl;
    logic [11:0]          mcfg;
    logic [2:0][23:0]     mint;
    logic [15:0]          dincfg;
    logic [31:0]          decouple;
    logic [31:0]          occfg;
    logic [3:0]           irq_stat;
    logic [3:0]           irq_mask;
    logic                 dec_alarm;
    logic                 oc_warn;
    logic                 inverse_time_overcurrent_alarm;
    logic [71:0]          acc;
    logic                 warn_o;
    logic                 shut_o;
    logic                 trip_o;
    logic                 irq_o;
    logic [31:0]          rdata;
  } gpa_state_t;

  localparam gpa_state_t GPA_STATE_RST = '{
    remain:   {3{`GPA_REMAIN_RST}},
    ctrl:     `GPA_CTRL_RST,
    mcfg:     `GPA_MCFG_RST,
    mint:     {3{`GPA_MINT_RST}},
    dincfg:   `GPA_DINCFG_RST,
    decouple: `GPA_DECOUPLE_RST,
    occfg:    `GPA_OCCFG_RST,
    default:  '0
  };

endpackage

/* src/gpa_top.sv */
// Maintenance, mains decoupling and overcurrent protection with register port
`timescale 1ns/100ps
`default_nettype none

module gpa_top #(
  parameter logic [31:0] CYC_PER_SEC    = `GPA_CLK_HZ,
  parameter logic [31:0] CYC_PER_MS     = `GPA_CLK_HZ / `GPA_MS_PER_S,
  parameter logic [31:0] STOP_HOLD_CYC  = `GPA_STOP_HOLD_S * `GPA_CLK_HZ,
  parameter logic [31:0] COMBO_HOLD_CYC = `GPA_COMBO_HOLD_MS * (`GPA_CLK_HZ / `GPA_MS_PER_S)
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [31:0] rd_data_out,
  // Operator pins and digital inputs
  input  wire logic        stop_btn_in,
  input  wire logic        mute_btn_in,
  input  wire logic        tick_btn_in,
  input  wire logic        paralleled_in,
  input  wire logic        engine_running_in,
  input  wire logic [3:0]  din_in,
  // Display and calendar logic
  input  wire logic [1:0]  page_level_in,
  input  wire logic        pin_ok_in,
  input  wire logic        month_tick_in,
  // Measurements
  input  wire logic [15:0] i_l1_in,
  input  wire logic [15:0] i_l2_in,
  input  wire logic [15:0] i_l3_in,
  input  wire logic [15:0] freq_slope_in,
  input  wire logic [15:0] vector_shift_in,
  // Alarm requests
  output logic             warning_out,
  output logic             shutdown_out,
  output logic             breaker_trip_out,
  output logic             irq_out
);

  gpa_pkg::gpa_state_t s_q;
  gpa_pkg::gpa_state_t s_d;

  logic [gpa_pkg::GPA_PIN_W-1:0] pins;
  logic        sec_tick;
  logic        ms_tick;
  logic        stop_edge;
  logic        stop_hold;
  logic        combo_hold;
  logic        din_raw;
  logic [3:0]  din_rise;
  logic [2:0]  maint_rst;
  logic [2:0]  level_en;
  logic [2:0]  date_en;
  logic [2:0]  level_shut;
  logic        wr_ctrl;
  logic        wr_cmd;
  logic [3:0]  irq_ev;
  logic        dec_set;
  logic        dec_clr;
  logic        oc_clr;
  logic [15:0] imax;
  logic [23:0] ia100;
  logic [23:0] it100;
  logic [23:0] excess;
  logic [47:0] it_sq;
  logic [71:0] thr;
  logic        over_warn;
  logic        over_inverse_time_overcurrent;
  logic        inverse_time_overcurrent_set;
  logic [31:0] rd_mux;

  assign pins = {din_in, engine_running_in, paralleled_in, tick_btn_in, mute_btn_in, stop_btn_in};

  always_comb begin
    s_d        = s_q;
    sec_tick   = 1'b0;
    ms_tick    = 1'b0;
    stop_edge  = 1'b0;
    stop_hold  = 1'b0;
    combo_hold = 1'b0;
    din_raw    = 1'b0;
    din_rise   = 4'h0;
    maint_rst  = 3'h0;
    irq_ev     = 4'h0;
    rd_mux     = 32'h0;
    level_en   = s_q.mcfg[`GPA_MCFG_EN_LSB +: 3];
    level_shut = s_q.mcfg[`GPA_MCFG_SHUT_LSB +: 3];
    date_en    = s_q.mcfg[`GPA_MCFG_DATE_LSB +: 3];
    wr_ctrl    = wr_en_in && (addr_in == `GPA_ADDR_CTRL);
    wr_cmd     = wr_en_in && (addr_in == `GPA_ADDR_CMD);

    // Three stages; a change is accepted once stages two and three agree
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.filt  = (s_q.sync2 & s_q.sync3) | (s_q.filt & (s_q.sync2 ^ s_q.sync3));

    // Second and millisecond ticks
    if (s_q.presc == CYC_PER_SEC - 32'h1) begin
      s_d.presc = 32'h0;
      sec_tick  = 1'b1;
    end else begin
      s_d.presc = s_q.presc + 32'h1;
    end
    if (s_q.ms_cnt == CYC_PER_MS - 32'h1) begin
      s_d.ms_cnt = 32'h0;
      ms_tick    = 1'b1;
    end else begin
      s_d.ms_cnt = s_q.ms_cnt + 32'h1;
    end

    s_d.stop_prev = s_q.filt[`GPA_PIN_STOP];
    stop_edge     = s_q.filt[`GPA_PIN_STOP] && !s_q.stop_prev;

    // Digital inputs: polarity, then activation delay in whole seconds
    for (int i = 0; i < 4; i++) begin
      din_raw = !(s_q.filt[`GPA_PIN_DIN + i] ^ s_q.dincfg[i]);
      if (!din_raw) begin
        s_d.din_cnt[i] = 8'h0;
      end else if (sec_tick && (s_q.din_cnt[i] < s_q.dincfg[15:8])) begin
        s_d.din_cnt[i] = s_q.din_cnt[i] + 8'h1;
      end
      s_d.din_act[i] = din_raw && (s_d.din_cnt[i] >= s_q.dincfg[15:8]);
      din_rise[i]    = s_d.din_act[i] && !s_q.din_act[i];
    end

    // Stop held on a level page; the count saturates so the reset fires once per hold
    if (s_q.filt[`GPA_PIN_STOP] && (page_level_in != 2'h0)
        && (!s_q.ctrl[`GPA_CTRL_PIN_REQ] || pin_ok_in)) begin
      if (s_q.stop_cnt != STOP_HOLD_CYC) begin
        s_d.stop_cnt = s_q.stop_cnt + 32'h1;
      end
      stop_hold = (s_q.stop_cnt == STOP_HOLD_CYC - 32'h1);
    end else begin
      s_d.stop_cnt = 32'h0;
    end

    // Mute and tick held together briefly
    if (s_q.filt[`GPA_PIN_MUTE] && s_q.filt[`GPA_PIN_TICK]) begin
      if (s_q.combo_cnt != COMBO_HOLD_CYC) begin
        s_d.combo_cnt = s_q.combo_cnt + 32'h1;
      end
      combo_hold = (s_q.combo_cnt == COMBO_HOLD_CYC - 32'h1);
    end else begin
      s_d.combo_cnt = 32'h0;
    end

    // Accumulated engine run hours
    if (s_q.filt[`GPA_PIN_RUN] && sec_tick) begin
      if (s_q.run_sec == `GPA_SEC_PER_HOUR - 12'h1) begin
        s_d.run_sec   = 12'h0;
        s_d.run_hours = s_q.run_hours + 32'h1;
      end else begin
        s_d.run_sec = s_q.run_sec + 12'h1;
      end
    end

    // Maintenance levels
    for (int i = 0; i < 3; i++) begin
      maint_rst[i] = din_rise[i]
                   || (wr_cmd && wr_data_in[i])
                   || (stop_hold && (page_level_in == 2'(i + 1)));
      if (maint_rst[i]) begin
        s_d.remain[i] = 32'(s_q.mint[i][15:0]) * `GPA_SEC_PER_HOUR;
        s_d.months[i] = 8'h0;
        s_d.due[i]    = 1'b0;
      end else begin
        if (s_q.filt[`GPA_PIN_RUN] && sec_tick && (s_q.remain[i] != 32'h0)) begin
          s_d.remain[i] = s_q.remain[i] - 32'h1;
        end
        if (month_tick_in && (s_q.months[i] != 8'hff)) begin
          s_d.months[i] = s_q.months[i] + 8'h1;
        end
        s_d.due[i] = level_en[i] && ((s_q.remain[i] == 32'h0)
                     || (date_en[i] && (s_q.months[i] >= s_q.mint[i][23:16])));
      end
    end
    irq_ev[`GPA_IRQ_MAINT] = |(s_d.due & ~s_q.due);

    // Mains decoupling; detection is held off unless paralleled
    dec_set = s_q.filt[`GPA_PIN_PAR]
              && (((s_q.decouple[15:0] != 16'h0) && (freq_slope_in >= s_q.decouple[15:0]))
              || ((s_q.decouple[31:16] != 16'h0)
              && (vector_shift_in >= s_q.decouple[31:16])));
    dec_clr = stop_edge || din_rise[`GPA_DIN_DEC_CLR] || combo_hold
              || (wr_cmd && wr_data_in[`GPA_CMD_DEC_CLR]);
    s_d.dec_alarm = dec_set || (s_q.dec_alarm && !dec_clr);
    irq_ev[`GPA_IRQ_DECOUPLE] = dec_set && !s_q.dec_alarm;

    // Overcurrent, all figures scaled by 100 so the percent setting needs no divide
    imax = (i_l1_in >= i_l2_in) ? i_l1_in : i_l2_in;
    imax = (imax >= i_l3_in) ? imax : i_l3_in;
    ia100 = 24'(imax) * 24'h000064;
    it100 = 24'(s_q.occfg[15:0]) * 24'(s_q.occfg[23:16]);
    over_warn = (it100 != 24'h0) && (ia100 >= it100);
    over_inverse_time_overcurrent = (it100 != 24'h0) && (ia100 > it100);
    excess = over_inverse_time_overcurrent ? (ia100 - it100) : 24'h0;
    it_sq  = 48'(it100) * 48'(it100);
    // Sum of squared excess per ms reaches t * 1000 * It^2 when elapsed equals trip time
    thr = 72'(s_q.occfg[31:24]) * 72'(`GPA_MS_PER_S) * 72'(it_sq);
    oc_clr = stop_edge || (wr_cmd && wr_data_in[`GPA_CMD_OC_CLR]);

    if (s_q.ctrl[`GPA_CTRL_WARN_EN] && over_warn) begin
      s_d.oc_warn = 1'b1;
    end else if (!s_q.ctrl[`GPA_CTRL_LATCH_ALL] || oc_clr) begin
      s_d.oc_warn = 1'b0;
    end
    irq_ev[`GPA_IRQ_OC_WARN] = s_d.oc_warn && !s_q.oc_warn;

    if (!s_q.ctrl[`GPA_CTRL_INVERSE_TIME_OVERCURRENT_EN]) begin
      s_d.acc = 72'h0;
    end else if (ms_tick) begin
      if (over_inverse_time_overcurrent) begin
        // Both factors widened first so the square keeps its upper bits
        s_d.acc = s_q.acc + (72'(excess) * 72'(excess));
      end else begin
        // Slow decay keeps heat from a recent overload
        s_d.acc = s_q.acc - (s_q.acc >> `GPA_COOL_SHIFT);
      end
    end
    inverse_time_overcurrent_set = s_q.ctrl[`GPA_CTRL_INVERSE_TIME_OVERCURRENT_EN] && over_inverse_time_overcurrent && (s_q.acc >= thr);
    s_d.inverse_time_overcurrent_alarm = inverse_time_overcurrent_set || (s_q.inverse_time_overcurrent_alarm && !oc_clr);
    irq_ev[`GPA_IRQ_INVERSE_TIME_OVERCURRENT] = inverse_time_overcurrent_set && !s_q.inverse_time_overcurrent_alarm;

    // Register writes
    if (wr_ctrl) begin
      s_d.ctrl = wr_data_in[7:0];
    end
    if (wr_en_in) begin
      case (addr_in)
        `GPA_ADDR_MCFG:     s_d.mcfg     = wr_data_in[11:0];
        `GPA_ADDR_MINT0:    s_d.mint[0]  = wr_data_in[23:0];
        `GPA_ADDR_MINT1:    s_d.mint[1]  = wr_data_in[23:0];
        `GPA_ADDR_MINT2:    s_d.mint[2]  = wr_data_in[23:0];
        `GPA_ADDR_DINCFG:   s_d.dincfg   = wr_data_in[15:0];
        `GPA_ADDR_DECOUPLE: s_d.decouple = wr_data_in;
        `GPA_ADDR_OCCFG:    s_d.occfg    = wr_data_in;
        `GPA_ADDR_IRQ_MASK: s_d.irq_mask = wr_data_in[3:0];
        default:            s_d.mcfg     = s_q.mcfg;
      endcase
    end

    // Sticky events; a new event beats a simultaneous write-one clear
    if (wr_en_in && (addr_in == `GPA_ADDR_IRQ_STAT)) begin
      s_d.irq_stat = (s_q.irq_stat & ~wr_data_in[3:0]) | irq_ev;
    end else begin
      s_d.irq_stat = s_q.irq_stat | irq_ev;
    end
    s_d.irq_o = |(s_q.irq_stat & s_q.irq_mask);

    // Alarm requests
    s_d.warn_o = |(s_q.due & ~level_shut) || s_q.oc_warn;
    s_d.shut_o = |(s_q.due & level_shut)
                 || (s_q.inverse_time_overcurrent_alarm && s_q.ctrl[`GPA_CTRL_INVERSE_TIME_OVERCURRENT_SHUT]);
    s_d.trip_o = s_q.dec_alarm
                 || (s_q.inverse_time_overcurrent_alarm && !s_q.ctrl[`GPA_CTRL_INVERSE_TIME_OVERCURRENT_SHUT]);

    // Read data stand only in the cycle after the strobe
    case (addr_in)
      `GPA_ADDR_CTRL:      rd_mux = {24'h0, s_q.ctrl};
      `GPA_ADDR_MCFG:      rd_mux = {20'h0, s_q.mcfg};
      `GPA_ADDR_MINT0:     rd_mux = {8'h0, s_q.mint[0]};
      `GPA_ADDR_MINT1:     rd_mux = {8'h0, s_q.mint[1]};
      `GPA_ADDR_MINT2:     rd_mux = {8'h0, s_q.mint[2]};
      `GPA_ADDR_DINCFG:    rd_mux = {16'h0, s_q.dincfg};
      `GPA_ADDR_DECOUPLE:  rd_mux = s_q.decouple;
      `GPA_ADDR_OCCFG:     rd_mux = s_q.occfg;
      `GPA_ADDR_STATUS:    rd_mux = {24'h0, s_q.filt[`GPA_PIN_RUN], s_q.filt[`GPA_PIN_PAR],
                                     s_q.inverse_time_overcurrent_alarm, s_q.oc_warn, s_q.dec_alarm, s_q.due};
      `GPA_ADDR_IRQ_STAT:  rd_mux = {28'h0, s_q.irq_stat};
      `GPA_ADDR_IRQ_MASK:  rd_mux = {28'h0, s_q.irq_mask};
      `GPA_ADDR_RUN_HOURS: rd_mux = s_q.run_hours;
      default:             rd_mux = 32'h0;
    endcase
    s_d.rdata = rd_en_in ? rd_mux : 32'h0;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= gpa_pkg::GPA_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_out      = s_q.rdata;
  assign warning_out      = s_q.warn_o;
  assign shutdown_out     = s_q.shut_o;
  assign breaker_trip_out = s_q.trip_o;
  assign irq_out          = s_q.irq_o;

endmodule

`default_nettype wire

/* test/gpa_plant_model.sv */
// Breaker and mains model on the far side of the protection block
`timescale 1ns/100ps
`default_nettype none
module gpa_plant_model #(
  parameter int OPEN_DLY = 10
) (
  // Clock and commands
  input  wire logic        mclk_in,
  input  wire logic        close_in,
  input  wire logic        mains_fail_in,
  input  wire logic        trip_in,
  // Plant state
  output logic             paralleled_out,
  output logic      [15:0] slope_out
);
  logic par_q = 1'b0;
  int   open_cnt = 0;
  // Breaker mechanism is slow, so the trip request must stand for a while
  always @(posedge mclk_in) begin
    if (trip_in && par_q) begin
      open_cnt <= open_cnt + 1;
      if (open_cnt == OPEN_DLY) begin
        par_q <= 1'b0;
      end
    end else begin
      open_cnt <= 0;
      if (close_in) begin
        par_q <= 1'b1;
      end
    end
  end
  assign paralleled_out = par_q;
  // Slope is measured on the mains side, also with the breaker open
  assign slope_out = mains_fail_in ? 16'h0080 : 16'h0000;
endmodule
`default_nettype wire

/* test/gpa_top_properties.sv */
// Port-level properties of the protection block
`timescale 1ns/100ps
`default_nettype none
module gpa_prot_chk (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  // Watched ports
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        stop_btn_in,
  input wire logic        mute_btn_in,
  input wire logic        paralleled_in,
  input wire logic [3:0]  din_in,
  input wire logic [15:0] i_l1_in,
  input wire logic [15:0] i_l2_in,
  input wire logic [15:0] i_l3_in,
  input wire logic [15:0] freq_slope_in,
  input wire logic [15:0] vector_shift_in,
  input wire logic        warning_out,
  input wire logic        breaker_trip_out,
  input wire logic        irq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // No phase at or above trip level and no register write
  wire logic calm = (i_l1_in < 16'h01f4) && (i_l2_in < 16'h01f4) && (i_l3_in < 16'h01f4)
                    && !wr_en_in;
  sequence s_par_fault;
    (paralleled_in && freq_slope_in >= 16'h0040) [*8];
  endsequence
  sequence s_stop_press;
    $rose(stop_btn_in) ##0 (stop_btn_in && !paralleled_in && calm
      && freq_slope_in == 16'h0000 && vector_shift_in == 16'h0000) [*8];
  endsequence
  sequence s_no_clear;
    (!stop_btn_in && !din_in[3] && !mute_btn_in && !wr_en_in) [*8];
  endsequence
  chk_rd_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
    else $error("read data not zero outside read slot");
  chk_rd_unmapped: assert property (rd_en_in && addr_in == 8'h3c |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property (wr_en_in && addr_in == 8'h2c && wr_data_in[3:0] == 4'h0
    |-> ##2 !irq_out)
    else $error("interrupt high with empty mask");
  chk_dec_trip: assert property (s_par_fault |=> breaker_trip_out)
    else $error("slope fault while paralleled did not trip");
  chk_dec_hold: assert property (s_no_clear ##0 breaker_trip_out |=> breaker_trip_out)
    else $error("trip dropped without a clear");
  chk_dec_inhibit: assert property ((!paralleled_in && calm) [*8] ##0 !breaker_trip_out
    |=> !breaker_trip_out)
    else $error("trip raised while not paralleled");
  chk_warn_level: assert property ((i_l2_in >= 16'h01f4) [*4] |=> warning_out)
    else $error("no warning at trip current");
  chk_stop_clear: assert property (s_stop_press |=> !breaker_trip_out)
    else $error("stop press did not clear trip");
endmodule
bind gpa_top gpa_prot_chk chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .stop_btn_in(stop_btn_in), .mute_btn_in(mute_btn_in),
  .paralleled_in(paralleled_in), .din_in(din_in), .i_l1_in(i_l1_in), .i_l2_in(i_l2_in),
  .i_l3_in(i_l3_in), .freq_slope_in(freq_slope_in), .vector_shift_in(vector_shift_in),
  .warning_out(warning_out), .breaker_trip_out(breaker_trip_out), .irq_out(irq_out));
`default_nettype wire

/* test/gpa_top_tb.sv */
// Self-checking bench of the generator protection block
`timescale 1ns/100ps
`default_nettype none
module gpa_top_tb;
  logic        mclk_in, rst_n_in, wen, ren, stop, mute, tick, close, mfail, run;
  logic        pin_ok, month, par, warning_out, shutdown_out, breaker_trip_out, irq_out;
  logic [7:0]  addr;
  logic [31:0] wdata, rd_data_out;
  logic [3:0]  din;
  logic [1:0]  page;
  logic [15:0] l1, l2, l3, slope, vsh;
  int          failures = 0, num_checks = 0, n, e;
  logic [39:0] rows [14] = '{{8'h00, 32'h3}, {8'h04, 32'h0}, {8'h08, 32'h1000a},
    {8'h0c, 32'h1000a}, {8'h10, 32'h1000a}, {8'h14, 32'h10f}, {8'h18, 32'ha00040},
    {8'h1c, 32'h246401f4}, {8'h20, 32'h0}, {8'h24, 32'h0}, {8'h28, 32'h0},
    {8'h2c, 32'h0}, {8'h30, 32'h0}, {8'h3c, 32'h0}};

  gpa_top #(.CYC_PER_SEC(32'ha), .CYC_PER_MS(32'h5), .STOP_HOLD_CYC(32'h1f4),
    .COMBO_HOLD_CYC(32'h19)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wen), .rd_en_in(ren),
    .rd_data_out(rd_data_out), .stop_btn_in(stop), .mute_btn_in(mute), .tick_btn_in(tick),
    .paralleled_in(par), .engine_running_in(run), .din_in(din), .page_level_in(page),
    .pin_ok_in(pin_ok), .month_tick_in(month), .i_l1_in(l1), .i_l2_in(l2), .i_l3_in(l3),
    .freq_slope_in(slope), .vector_shift_in(vsh), .warning_out(warning_out),
    .shutdown_out(shutdown_out), .breaker_trip_out(breaker_trip_out), .irq_out(irq_out));
  gpa_plant_model plant_u (.mclk_in(mclk_in), .close_in(close), .mains_fail_in(mfail),
    .trip_in(breaker_trip_out), .paralleled_out(par), .slope_out(slope));

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic conclude;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ck(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wen <= 1'b1;
    @(posedge mclk_in);
    wen <= 1'b0;
  endtask
  // Read data stand only in the slot after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    addr <= a;
    ren <= 1'b1;
    @(posedge mclk_in);
    ren <= 1'b0;
    // Sample after the launching edge has settled, then return on an edge
    #1;
    check(rd_data_out, exp);
    @(posedge mclk_in);
  endtask
  task automatic wait_out(input int b, input int lim, output int c);
    c = 0;
    while ((b ? shutdown_out : breaker_trip_out) !== 1'b1 && c < lim) begin
      @(posedge mclk_in);
      c++;
    end
    if (c == lim) begin
      failures++;
      conclude();
    end
  endtask
  task automatic mtick;
    month <= 1'b1;
    cyc(1);
    month <= 1'b0;
    cyc(4);
  endtask
  task automatic hold_stop;
    stop <= 1'b1;
    cyc(520);
    stop <= 1'b0;
    cyc(4);
  endtask

  initial begin
    {rst_n_in, wen, ren, stop, mute, tick, close, mfail, run, pin_ok, month} = '0;
    {addr, wdata, din, page, l1, l2, l3, vsh} = '0;
    cyc(12);
    rst_n_in <= 1'b1;
    for (int r = 0; r < 14; r++) begin
      rchk(rows[r][39:32], rows[r][31:0]);
    end
    wr(8'h2c, 32'hf);
    mfail <= 1'b1;
    cyc(30);
    ck(breaker_trip_out, 1'b0);
    // Each pass clears the latched trip by a different path
    // Last pass trips on vector shift instead of slope
    for (int k = 0; k < 4; k++) begin
      mfail <= (k != 3);
      vsh <= (k == 3) ? 16'h00a0 : 16'h0000;
      close <= 1'b1;
      cyc(1);
      close <= 1'b0;
      cyc(40);
      ck(breaker_trip_out, 1'b1);
      ck(par, 1'b0);
      mfail <= 1'b0;
      vsh <= 16'h0000;
      cyc(10);
      ck(breaker_trip_out, 1'b1);
      case (k)
        0: begin
          stop <= 1'b1;
          cyc(8);
          stop <= 1'b0;
        end
        1: begin
          din[3] <= 1'b1;
          cyc(60);
          din[3] <= 1'b0;
        end
        2: begin
          {mute, tick} <= 2'b11;
          cyc(35);
          {mute, tick} <= 2'b00;
        end
        default: wr(8'h20, 32'h8);
      endcase
      cyc(8);
      ck(breaker_trip_out, 1'b0);
    end
    ck(irq_out, 1'b1);
    rchk(8'h28, 32'h2);
    wr(8'h28, 32'h2);
    cyc(3);
    ck(irq_out, 1'b0);
    l2 <= 16'h01f4;
    cyc(6);
    ck(warning_out, 1'b1);
    l2 <= 16'h01f3;
    cyc(6);
    ck(warning_out, 1'b0);
    // Latched warnings hold until an explicit clear
    wr(8'h00, 32'hb);
    l2 <= 16'h01f4;
    cyc(6);
    l2 <= 16'h01f3;
    cyc(6);
    ck(warning_out, 1'b1);
    wr(8'h20, 32'h10);
    cyc(4);
    ck(warning_out, 1'b0);
    // Multiplier of one keeps the trip times short
    wr(8'h1c, 32'h016401f4);
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h3);
      // Second pass puts the heavier load on another line
      {l1, l3} <= k ? 32'h03e805dc : 32'h03e80000;
      wait_out(0, 8000, n);
      {l1, l3} <= 32'h00000000;
      e = 5000 / ((k + 1) * (k + 1));
      ck(n >= e * 95 / 100 && n <= e * 105 / 100 + 10, 1'b1);
      wr(8'h20, 32'h10);
      cyc(4);
      ck(breaker_trip_out, 1'b0);
    end
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h7);
    l1 <= 16'h03e8;
    cyc(3000);
    ck(shutdown_out, 1'b0);
    l1 <= 16'h0000;
    cyc(500);
    l1 <= 16'h03e8;
    wait_out(1, 3000, n);
    ck(n >= 1750 && n <= 2250, 1'b1);
    l1 <= 16'h0000;
    wr(8'h20, 32'h10);
    wr(8'h04, 32'h723);
    mtick();
    rchk(8'h24, 32'h3);
    ck(shutdown_out, 1'b1);
    ck(warning_out, 1'b1);
    wr(8'h20, 32'h1);
    cyc(3);
    rchk(8'h24, 32'h2);
    ck(warning_out, 1'b0);
    din[1] <= 1'b1;
    cyc(60);
    din[1] <= 1'b0;
    cyc(4);
    rchk(8'h24, 32'h0);
    ck(shutdown_out, 1'b0);
    mtick();
    rchk(8'h24, 32'h3);
    page <= 2'h1;
    hold_stop();
    rchk(8'h24, 32'h2);
    wr(8'h00, 32'h17);
    page <= 2'h2;
    hold_stop();
    rchk(8'h24, 32'h2);
    pin_ok <= 1'b1;
    hold_stop();
    rchk(8'h24, 32'h0);
    // One-hour interval on level three, shutdown type, counted only while running
    wr(8'h10, 32'h00ff0001);
    wr(8'h20, 32'h4);
    wr(8'h04, 32'h047);
    run <= 1'b1;
    wait_out(1, 36200, n);
    ck(n >= 35950 && n <= 36050, 1'b1);
    rchk(8'h30, 32'h1);
    rchk(8'h24, 32'h84);
    run <= 1'b0;
    rchk(8'h28, 32'hd);
    wr(8'h2c, 32'h0);
    cyc(3);
    ck(irq_out, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
